// ===== bcte_consts.vh
// Purpose: shared constants of the blinds command and learn encoder
// Assumes: 32-bit register bus, byte addresses, one word per register
// Notes: telegram bytes db6..db0 sit in tx_data[55:0], db6 on top
// Operation
// - goto: position and angle, 127 keeps value
// - stop and query carry channel only
// - set-parameters carries run, rotation, alarm fields
// - vertical run 500..30000 valid, below 500 reserved
// - run value 32767 keeps stored duration
// - rotation 1..254 ticks, 0 none, 255 keep
// - alarm action codes; alarm mode locks others
// - partial variant handles command codes 1..3 only
// - learn request maps seven slots to db6..db0
// - db6 bit7 selects one-way or two-way
// - db6 bit6 set means no response expected
// - db6 bits5:4 learn, delete, unspecified; 11 unused
// - db5 carries channel index from slot two
// - maker id: low eight db4, top three db3
`ifndef BCTE_CONSTS_VH
`define BCTE_CONSTS_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define BCTE_OFS_CTRL 8'h00
`define BCTE_OFS_STATUS 8'h20
`define BCTE_OFS_TX_LO 8'h24
`define BCTE_OFS_TX_HI 8'h28
`define BCTE_SLOT_LSB 2
`define BCTE_SLOT_MSB 4
`define BCTE_SLOT_TOP 8'h1c

// ------------------------------------------------------------
// control and status fields
// ------------------------------------------------------------
`define BCTE_CTRL_PARTIAL 0
`define BCTE_CTRL_GO_BLIND 1
`define BCTE_CTRL_GO_LEARN 2
`define BCTE_ST_BUSY 0
`define BCTE_ST_DONE 1
`define BCTE_ST_ERR 2
`define BCTE_ST_LOCK 3
`define BCTE_ST_CODE_LSB 4
`define BCTE_ERR_NONE 4'h0
`define BCTE_ERR_CMD 4'h1
`define BCTE_ERR_RANGE 4'h2
`define BCTE_ERR_LOCK 4'h3

// ------------------------------------------------------------
// bus answers
// ------------------------------------------------------------
`define BCTE_RESP_OKAY 2'h0
`define BCTE_RESP_DECERR 2'h3

// ------------------------------------------------------------
// blinds command codes and field limits
// ------------------------------------------------------------
`define BCTE_CMD_GOTO 16'h0001
`define BCTE_CMD_STOP 16'h0002
`define BCTE_CMD_QUERY 16'h0003
`define BCTE_CMD_SETP 16'h0005
`define BCTE_PCT_MAX 8'h64
`define BCTE_KEEP_PCT 8'h7f
`define BCTE_REPO_MAX 8'h02
`define BCTE_LOCK_NONE 8'h00
`define BCTE_LOCK_BLOCK 8'h01
`define BCTE_LOCK_ALARM 8'h02
`define BCTE_LOCK_FREE 8'h07
`define BCTE_RUN_MIN 16'h01f4
`define BCTE_RUN_MAX 16'h7530
`define BCTE_RUN_KEEP 16'h7fff
`define BCTE_ALARM_MAX 8'h03
`define BCTE_ALARM_KEEP 8'h07

// ------------------------------------------------------------
// learn request db6 fields
// ------------------------------------------------------------
`define BCTE_LRN_DIR 7
`define BCTE_LRN_NORESP 6
`define BCTE_LRN_REQ_MSB 5
`define BCTE_LRN_REQ_LSB 4
`define BCTE_LRN_REQ_BAD 2'h3

`endif

// ===== bcte_blind_enc.v
// Purpose: checks and packs one blinds actuator command
// Assumes: slots are stable while they are evaluated
// Notes: purely combinational; the top registers the result
`timescale 1ns/1ps
`include "bcte_consts.vh"

module bcte_blind_enc (
  // value slots one to seven
  input wire [111:0] slots,
  // mode
  input wire partial,
  input wire locked,
  // result
  output reg [55:0] data,
  output reg [3:0] err_code,
  output reg set_lock,
  output reg clr_lock
);

  wire [15:0] v1 = slots[15:0];
  wire [7:0] v2 = slots[23:16];
  wire [15:0] v3 = slots[47:32];
  wire [7:0] v4 = slots[55:48];
  wire [7:0] v5 = slots[71:64];
  wire [7:0] v6 = slots[87:80];

  wire pos_ok = (v3[7:0] <= `BCTE_PCT_MAX) || (v3[7:0] == `BCTE_KEEP_PCT);
  wire ang_ok = (v4 <= `BCTE_PCT_MAX) || (v4 == `BCTE_KEEP_PCT);
  wire lock_ok = (v6 <= `BCTE_LOCK_ALARM) || (v6 == `BCTE_LOCK_FREE);
  wire run_ok = ((v3 >= `BCTE_RUN_MIN) && (v3 <= `BCTE_RUN_MAX)) ||
                (v3 == `BCTE_RUN_KEEP);
  wire alarm_ok = (v5 <= `BCTE_ALARM_MAX) || (v5 == `BCTE_ALARM_KEEP);

  always @* begin
    data = 56'h00_0000_0000_0000;
    err_code = `BCTE_ERR_NONE;
    set_lock = 1'b0;
    clr_lock = 1'b0;
    case (v1)
      `BCTE_CMD_GOTO: begin
        data = {v1[7:0], v2, v3[7:0], v4, v5, v6, 8'h00};
        if (locked && v6 != `BCTE_LOCK_FREE) begin
          err_code = `BCTE_ERR_LOCK;
        end else if (!(pos_ok && ang_ok && lock_ok) ||
                     v5 > `BCTE_REPO_MAX) begin
          err_code = `BCTE_ERR_RANGE;
        end else begin
          set_lock = (v6 == `BCTE_LOCK_ALARM);
          clr_lock = (v6 == `BCTE_LOCK_FREE);
        end
      end
      `BCTE_CMD_STOP, `BCTE_CMD_QUERY: begin
        data = {v1[7:0], v2, 40'h00_0000_0000};
        if (locked) begin
          err_code = `BCTE_ERR_LOCK;
        end
      end
      `BCTE_CMD_SETP: begin
        data = {v1[7:0], v2, v3, v4, v5, 8'h00};
        if (partial) begin
          err_code = `BCTE_ERR_CMD;
        end else if (locked) begin
          err_code = `BCTE_ERR_LOCK;
        end else if (!(run_ok && alarm_ok)) begin
          err_code = `BCTE_ERR_RANGE;
        end
      end
      default: begin
        err_code = `BCTE_ERR_CMD;
      end
    endcase
  end

endmodule // bcte_blind_enc

// ===== bcte_learn_enc.v
// Purpose: packs the universal learn request from seven slots
// Assumes: slot one holds the db6 control byte in its low bits
// Notes: purely combinational; low nibble of db6 is sent as zero
`timescale 1ns/1ps
`include "bcte_consts.vh"

module bcte_learn_enc (
  // value slots one to seven
  input wire [111:0] slots,
  // result
  output reg [55:0] data,
  output reg bad
);

  reg [7:0] db6;

  always @* begin
    db6 = 8'h00;
    db6[`BCTE_LRN_DIR] = slots[`BCTE_LRN_DIR];
    db6[`BCTE_LRN_NORESP] = slots[`BCTE_LRN_NORESP];
    db6[`BCTE_LRN_REQ_MSB:`BCTE_LRN_REQ_LSB] =
      slots[`BCTE_LRN_REQ_MSB:`BCTE_LRN_REQ_LSB];
    bad = (db6[`BCTE_LRN_REQ_MSB:`BCTE_LRN_REQ_LSB] ==
           `BCTE_LRN_REQ_BAD);
    data = {db6,
            slots[23:16],
            slots[39:32],
            5'h00, slots[50:48],
            slots[71:64],
            slots[87:80],
            slots[103:96]};
  end

endmodule // bcte_learn_enc

// ===== bcte_top.v
// Purpose: register front end and dispatcher of encoded telegrams
// Assumes: tx_ready comes from logic on clk
// Notes: one command at a time; go while busy is ignored
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
`include "bcte_consts.vh"

module bcte_top #(
  parameter ADDR_W = 8,
  parameter SLOTS = 7
) (
  // clock and reset
  input wire clk,
  input wire reset,
  input wire ce,
  // write address
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // read address
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // telegram to the radio side
  output reg [55:0] tx_data,
  output reg tx_learn,
  output reg tx_valid,
  input wire tx_ready,
  // actuator alarm lock as tracked here
  output reg alarm_lock
);

  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  localparam ST_IDLE = 2'b01;
  localparam ST_SEND = 2'b10;

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg aw_full_q;
  reg w_full_q;
  reg [ADDR_W-1:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg partial_q;
  reg done_q;
  reg err_q;
  reg [3:0] code_q;
  wire [16*SLOTS-1:0] slots;
  wire wr_fire;
  wire rd_fire;
  wire [ADDR_W-1:0] wa;
  wire wa_slot;
  wire [2:0] wa_idx;
  wire go_blind;
  wire go_learn;
  wire st_clr_done;
  wire st_clr_err;
  wire [55:0] blind_data;
  wire [3:0] blind_code;
  wire blind_set_lock;
  wire blind_clr_lock;
  wire [55:0] learn_data;
  wire learn_bad;
  wire idle;
  wire sent;
  reg [31:0] rd_word;
  reg rd_ok;

  // ------------------------------------------------------------
  // write channel
  // ------------------------------------------------------------
  assign wr_fire = aw_full_q && w_full_q && !s_axi_bvalid;
  assign wa = aw_addr_q;
  assign wa_idx = wa[`BCTE_SLOT_MSB:`BCTE_SLOT_LSB];
  assign wa_slot = (wa[1:0] == 2'h0) && (wa != `BCTE_OFS_CTRL) &&
                   (wa <= `BCTE_SLOT_TOP);

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= {ADDR_W{1'b0}};
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `BCTE_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (wa_slot || wa == `BCTE_OFS_CTRL || wa == `BCTE_OFS_STATUS) begin
          s_axi_bresp <= `BCTE_RESP_OKAY;
        end else begin
          s_axi_bresp <= `BCTE_RESP_DECERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // value slots
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < SLOTS; gi = gi + 1) begin : g_slot
      reg [15:0] val_q;
      wire hit = wr_fire && wa_slot && (wa_idx == gi + 1);
      always @(posedge clk or posedge reset) begin
        if (reset) begin
          val_q <= 16'h0000;
        end else if (ce && hit) begin
          if (w_strb_q[0]) begin
            val_q[7:0] <= w_data_q[7:0];
          end
          if (w_strb_q[1]) begin
            val_q[15:8] <= w_data_q[15:8];
          end
        end
      end
      assign slots[16*gi+15:16*gi] = val_q;
    end
  endgenerate

  // ------------------------------------------------------------
  // control and status writes
  // ------------------------------------------------------------
  wire ctrl_wr = wr_fire && (wa == `BCTE_OFS_CTRL) && w_strb_q[0];
  wire stat_wr = wr_fire && (wa == `BCTE_OFS_STATUS) && w_strb_q[0];
  assign go_blind = ctrl_wr && w_data_q[`BCTE_CTRL_GO_BLIND];
  assign go_learn = ctrl_wr && w_data_q[`BCTE_CTRL_GO_LEARN] && !go_blind;
  assign st_clr_done = stat_wr && w_data_q[`BCTE_ST_DONE];
  assign st_clr_err = stat_wr && w_data_q[`BCTE_ST_ERR];

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      partial_q <= 1'b0;
    end else if (ce && ctrl_wr) begin
      partial_q <= w_data_q[`BCTE_CTRL_PARTIAL];
    end
  end

  // ------------------------------------------------------------
  // encoders
  // ------------------------------------------------------------
  bcte_blind_enc u_blind (
    .slots(slots),
    .partial(ctrl_wr ? w_data_q[`BCTE_CTRL_PARTIAL] : partial_q),
    .locked(alarm_lock),
    .data(blind_data),
    .err_code(blind_code),
    .set_lock(blind_set_lock),
    .clr_lock(blind_clr_lock)
  );

  bcte_learn_enc u_learn (
    .slots(slots),
    .data(learn_data),
    .bad(learn_bad)
  );

  // ------------------------------------------------------------
  // dispatcher
  // ------------------------------------------------------------
  assign idle = state_q[0];
  assign sent = state_q[1] && tx_valid && tx_ready;
  wire blind_ok = go_blind && idle && (blind_code == `BCTE_ERR_NONE);
  wire blind_bad = go_blind && idle && (blind_code != `BCTE_ERR_NONE);
  wire learn_ok = go_learn && idle && !learn_bad;
  wire learn_nok = go_learn && idle && learn_bad;

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (blind_ok || learn_ok) begin
          state_d = ST_SEND;
        end
      end
      ST_SEND: begin
        if (sent) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_IDLE;
      tx_data <= 56'h00_0000_0000_0000;
      tx_learn <= 1'b0;
      tx_valid <= 1'b0;
      alarm_lock <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      if (blind_ok) begin
        tx_data <= blind_data;
        tx_learn <= 1'b0;
        tx_valid <= 1'b1;
        if (blind_set_lock) begin
          alarm_lock <= 1'b1;
        end else if (blind_clr_lock) begin
          alarm_lock <= 1'b0;
        end
      end else if (learn_ok) begin
        tx_data <= learn_data;
        tx_learn <= 1'b1;
        tx_valid <= 1'b1;
      end else if (sent) begin
        tx_valid <= 1'b0;
      end
    end
  end

  // sticky flags: a new event wins over a clear in the same cycle
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      done_q <= 1'b0;
      err_q <= 1'b0;
      code_q <= `BCTE_ERR_NONE;
    end else if (ce) begin
      if (sent) begin
        done_q <= 1'b1;
      end else if (st_clr_done) begin
        done_q <= 1'b0;
      end
      if (blind_bad) begin
        err_q <= 1'b1;
        code_q <= blind_code;
      end else if (learn_nok) begin
        err_q <= 1'b1;
        code_q <= `BCTE_ERR_RANGE;
      end else if (st_clr_err) begin
        err_q <= 1'b0;
        code_q <= `BCTE_ERR_NONE;
      end
    end
  end

  // ------------------------------------------------------------
  // read channel
  // ------------------------------------------------------------
  always @* begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    if (s_axi_araddr == `BCTE_OFS_CTRL) begin
      rd_word[`BCTE_CTRL_PARTIAL] = partial_q;
    end else if (s_axi_araddr == `BCTE_OFS_STATUS) begin
      rd_word[`BCTE_ST_BUSY] = state_q[1];
      rd_word[`BCTE_ST_DONE] = done_q;
      rd_word[`BCTE_ST_ERR] = err_q;
      rd_word[`BCTE_ST_LOCK] = alarm_lock;
      rd_word[`BCTE_ST_CODE_LSB+3:`BCTE_ST_CODE_LSB] = code_q;
    end else if (s_axi_araddr == `BCTE_OFS_TX_LO) begin
      rd_word = tx_data[31:0];
    end else if (s_axi_araddr == `BCTE_OFS_TX_HI) begin
      rd_word[23:0] = tx_data[55:32];
    end else if (s_axi_araddr[1:0] == 2'h0 &&
                 s_axi_araddr <= `BCTE_SLOT_TOP) begin
      rd_word[15:0] = slots[16*(s_axi_araddr[`BCTE_SLOT_MSB:
                                `BCTE_SLOT_LSB]-1) +: 16];
    end else begin
      rd_ok = 1'b0;
    end
  end

  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `BCTE_RESP_OKAY;
    end else if (ce) begin
      if (rd_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? `BCTE_RESP_OKAY : `BCTE_RESP_DECERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // bcte_top

// ===== bcte_top_chk.sv
// Purpose: port checker of the blinds and learn encoder
// Assumes: ce held high
// Notes: bound to bcte_top at the foot of this file
`timescale 1ns/1ps
module bcte_top_chk (
  // clock and reset
  input wire clk,
  input wire reset,
  // telegram
  input wire [55:0] tx_data,
  input wire tx_learn,
  input wire tx_valid,
  input wire tx_ready,
  input wire alarm_lock
);
  wire [7:0] db6 = tx_data[55:48];
  wire blind = tx_valid && !tx_learn;
  // ----
  // telegram content
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_cmd_known: assert property (blind |-> db6 inside {1,2,3,5})
    else $error("unknown command sent");
  a_goto_pct: assert property (blind && db6 == 1 |->
    (tx_data[39:32] <= 100 || tx_data[39:32] == 127) &&
    (tx_data[31:24] <= 100 || tx_data[31:24] == 127))
    else $error("goto percent out of range");
  a_stop_zero: assert property (blind && db6 inside {2, 3} |->
    tx_data[39:0] == 0) else $error("stop or query not zero filled");
  a_run_span: assert property (blind && db6 == 5 |->
    tx_data[39:24] inside {[500:30000], 32767})
    else $error("run duration reserved");
  a_alarm_code: assert property (blind && db6 == 5 |->
    tx_data[15:8] inside {[0:3], 7}) else $error("alarm code reserved");
  a_tail_zero: assert property (blind |-> tx_data[7:0] == 0)
    else $error("unused byte not zero");
  a_learn_form: assert property (tx_valid && tx_learn |->
    tx_data[53:52] != 2'h3 && tx_data[51:48] == 0 && tx_data[31:27] == 0)
    else $error("learn request malformed");
  a_lock_gate: assert property ($rose(tx_valid) && !tx_learn &&
    $past(alarm_lock) |-> db6 == 1 && tx_data[15:8] == 7)
    else $error("command passed alarm lock");
  a_lock_src: assert property ($rose(alarm_lock) |-> !tx_learn &&
    db6 == 1 && tx_data[15:8] == 2) else $error("lock set without cause");
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid &&
    $stable(tx_data) && $stable(tx_learn)) else $error("telegram moved");
  c_learn: cover property (tx_valid && tx_learn && tx_ready);
  c_setp: cover property (blind && db6 == 5 && tx_ready);
  c_lock: cover property ($rose(alarm_lock));
  c_stall: cover property (tx_valid && !tx_ready ##1 tx_ready);
endmodule // bcte_top_chk

bind bcte_top bcte_top_chk bcte_top_chk_i (
  .clk(clk),
  .reset(reset),
  .tx_data(tx_data),
  .tx_learn(tx_learn),
  .tx_valid(tx_valid),
  .tx_ready(tx_ready),
  .alarm_lock(alarm_lock)
);

// ===== bcte_radio_model.sv
// Purpose: radio actuator side, takes telegrams with random stalls
// Assumes: same clock as the encoder
// Notes: keeps the last telegram taken and a count
`timescale 1ns/1ps
module bcte_radio_model (
  // clock and reset
  input wire clk,
  input wire reset,
  // telegram
  input wire [55:0] tx_data,
  input wire tx_learn,
  input wire tx_valid,
  output reg tx_ready,
  // taken
  output reg [55:0] got_data,
  output reg got_learn,
  output reg [15:0] n_got
);
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_ready <= 1'b0;
      got_data <= 56'h0;
      got_learn <= 1'b0;
      n_got <= 16'h0000;
    end else begin
      tx_ready <= ($urandom % 3) != 0;
      if (tx_valid && tx_ready) begin
        got_data <= tx_data;
        got_learn <= tx_learn;
        n_got <= n_got + 16'h0001;
      end
    end
  end
endmodule // bcte_radio_model

// ===== bcte_top_tb.sv
// Purpose: self-checking bench of the blinds and learn encoder
// Assumes: byte addresses of the register map
// Notes: random commands with fixed seed plus corner cases
`timescale 1ns/1ps
module bcte_top_tb;
  logic clk, reset, ce, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  wire awready, wready, bvalid, arready, rvalid, tx_learn, tx_valid;
  wire tx_ready, alarm_lock, got_learn;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [55:0] tx_data, got_data;
  wire [15:0] n_got;
  int n_fail, samples_checked;
  logic lock_m;
  logic [15:0] s [1:7];
  bcte_top bcte_top_i (
    .clk(clk), .reset(reset), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .tx_data(tx_data), .tx_learn(tx_learn),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .alarm_lock(alarm_lock)
  );
  bcte_radio_model bcte_radio_model_i (
    .clk(clk), .reset(reset), .tx_data(tx_data), .tx_learn(tx_learn),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .got_data(got_data),
    .got_learn(got_learn), .n_got(n_got)
  );
  // ----
  // tasks
  // ----
  task automatic chk(input string w, input logic [63:0] v, e);
    samples_checked++;
    if (v !== e) begin
      n_fail++;
      $display("FAIL %s exp %h seen %h", w, e, v);
    end
  endtask
  task automatic end_of_test;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    bit ad, dd;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge clk);
      if (awready) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (wready) begin
        dd = 1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    @(posedge clk);
    while (!bvalid) @(posedge clk);
    bready <= 1'b0;
    chk("bresp", bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, output logic [33:0] rr);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge clk);
    while (!arready) @(posedge clk);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge clk);
    rready <= 1'b0;
    rr = {rresp, rdata};
  endtask
  function automatic logic [59:0] expect_enc(input logic l, p);
    logic [15:0] c;
    c = s[1];
    if (l) begin
      if (c[5:4] == 2'h3) return {4'h2, 56'h0};
      return {4'h0, c[7:4], 4'h0, s[2][7:0],
              s[3][7:0], 5'h0, s[4][2:0], s[5][7:0],
              s[6][7:0], s[7][7:0]};
    end
    if (!(c inside {1, 2, 3, 5}) || (c == 5 && p)) return {4'h1, 56'h0};
    if (lock_m && !(c == 1 && s[6] == 7)) return {4'h3, 56'h0};
    if (c == 1) begin
      if ((s[3] > 100 && s[3] != 127) || (s[4] > 100 && s[4] != 127) ||
          s[5] > 2 || !(s[6] inside {0, 1, 2, 7})) return {4'h2, 56'h0};
      return {12'h001, s[2][7:0], s[3][7:0], s[4][7:0],
              s[5][7:0], s[6][7:0], 8'h00};
    end
    if (c == 5) begin
      if (!(s[3] inside {[500:30000], 32767}) ||
          !(s[5] inside {[0:3], 7})) return {4'h2, 56'h0};
      return {12'h005, s[2][7:0], s[3], s[4][7:0], s[5][7:0], 8'h00};
    end
    return {4'h0, c[7:0], s[2][7:0], 40'h0};
  endfunction
  task automatic run(input logic l, p);
    logic [59:0] e;
    logic [33:0] rr;
    logic [15:0] n0;
    e = expect_enc(l, p);
    for (int i = 1; i <= 7; i++) wr(8'(4 * i), {16'h0000, s[i]}, 2'h0);
    n0 = n_got;
    wr(8'h00, {29'h0, l, !l, p}, 2'h0);
    for (int k = 0; n_got == n0 && k < 40; k++) @(posedge clk);
    chk("sent", 16'(n_got - n0), e[59:56] == 0);
    if (e[59:56] == 0) begin
      chk("data", got_data, e[55:0]);
      chk("kind", got_learn, l);
      if (!l && s[1] == 1 && s[6] == 2) lock_m = 1;
      if (!l && s[1] == 1 && s[6] == 7) lock_m = 0;
    end
    rd(8'h20, rr);
    chk("status", rr, {26'h0, e[59:56], lock_m, e[59:56] != 0,
        e[59:56] == 0, 1'b0});
    chk("lock", alarm_lock, lock_m);
    wr(8'h20, 32'h0000_0006, 2'h0);
  endtask
  task automatic cmd(input logic l, p, input logic [15:0] a, b, c, d,
                     e, f, g);
    s = '{a, b, c, d, e, f, g};
    run(l, p);
  endtask
  // ----
  // sequence
  // ----
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    end_of_test();
  end
  initial begin
    logic [33:0] rr;
    logic [33:0] hi;
    void'($urandom(12));
    {ce, reset, wstrb} = 6'h3f;
    {awvalid, wvalid, bready, arvalid, rready, lock_m} = 6'h00;
    {awaddr, araddr, wdata} = 48'h0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(8'h20, rr);
    chk("status0", rr, 34'h0);
    wr(8'h40, 32'h0000_0001, 2'h3);
    rd(8'h40, rr);
    chk("unmapped", rr, {2'h3, 32'h0});
    wr(8'h24, 32'h0000_0001, 2'h3);
    wr(8'h04, 32'hdead_1234, 2'h0);
    rd(8'h04, rr);
    chk("slot", rr, 34'h0_0000_1234);
    cmd(0, 0, 2, 5, 77, 9, 1, 2, 3);
    cmd(0, 1, 3, 6, 1, 1, 1, 1, 1);
    cmd(0, 0, 1, 1, 100, 127, 2, 0, 9);
    cmd(0, 0, 1, 1, 101, 0, 0, 0, 0);
    cmd(0, 0, 5, 1, 499, 0, 0, 0, 0);
    cmd(0, 0, 5, 2, 500, 255, 7, 0, 0);
    cmd(0, 0, 5, 2, 30000, 0, 3, 4, 5);
    cmd(0, 0, 5, 2, 30001, 1, 3, 0, 0);
    cmd(0, 0, 5, 2, 32767, 254, 4, 0, 0);
    cmd(0, 0, 5, 2, 32767, 254, 0, 0, 0);
    cmd(0, 1, 5, 1, 500, 1, 0, 0, 0);
    cmd(0, 1, 4, 1, 0, 0, 0, 0, 0);
    cmd(0, 0, 0, 1, 0, 0, 0, 0, 0);
    cmd(0, 0, 1, 1, 127, 127, 0, 2, 0);
    cmd(0, 0, 2, 1, 0, 0, 0, 0, 0);
    cmd(0, 0, 5, 1, 500, 1, 0, 0, 0);
    cmd(0, 0, 1, 1, 50, 50, 1, 7, 0);
    foreach (s[i]) s[i] = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      cmd(1, 0, 16'h369c >> (4 * i), 3, 16'h5a, 7, 2, 5, 16'hd2);
    end
    rd(8'h24, rr);
    rd(8'h28, hi);
    chk("tx_reg", {hi[23:0], rr[31:0]}, got_data);
    for (int n = 0; n < 30; n++) begin
      for (int i = 2; i <= 7; i++) s[i] = 16'($urandom % 256);
      case ($urandom % 5)
        0: begin
          s[1] = 16'h0001;
          s[3] = 16'($urandom % 104);
          s[4] = ($urandom % 2) ? 16'h007f : 16'($urandom % 101);
          s[5] = 16'($urandom % 3);
          s[6] = ($urandom % 2) ? 16'h0007 : 16'($urandom % 2);
          run(0, 0);
        end
        1: begin
          s[1] = 16'(2 + $urandom % 2);
          run(0, 1'($urandom % 2));
        end
        2: begin
          s[1] = 16'h0005;
          s[3] = ($urandom % 8) ? 16'(490 + $urandom % 29520) : 16'h7fff;
          s[5] = 16'($urandom % 8);
          run(0, 0);
        end
        3: begin
          s[1] = 16'($urandom % 256);
          s[4] = 16'($urandom % 8);
          run(1, 0);
        end
        default: begin
          s[1] = 16'(4 + $urandom % 12);
          run(0, 1'($urandom % 2));
        end
      endcase
    end
    end_of_test();
  end
endmodule // bcte_top_tb
